// File: hw/bbau_bcd_div.sv
// serial decimal divider: one quotient digit per step via restoring subtraction
`timescale 1ns/10ps
`default_nettype none
`include "bbau_consts.svh"
module bbau_bcd_div (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic reset,
    // link to the unit
    bbau_div_if.div   dv
);
    // digit-serial: 4 digit steps, each up to 9 subtracts, counted by dig
    logic [15:0] rem_q,  next_rem_q;
    logic [15:0] quo,    next_quo;
    logic [15:0] dsr,    next_dsr;
    logic [15:0] src,    next_src;
    logic [2:0]  dig,    next_dig;
    logic        busy,   next_busy;
    logic        done_r, next_done_r;
    logic [15:0] quo_o,  next_quo_o;
    logic [15:0] rem_o,  next_rem_o;
    logic [3:0]  qd;

    assign dv.done      = done_r;
    assign dv.quotient  = quo_o;
    assign dv.remainder = rem_o;

    // remainder kept in binary; digits of the dividend are fed in one per step
    always_comb begin
        next_rem_q  = rem_q;
        next_quo    = quo;
        next_dsr    = dsr;
        next_src    = src;
        next_dig    = dig;
        next_busy   = busy;
        next_done_r = 1'h0;
        next_quo_o  = quo_o;
        next_rem_o  = rem_o;
        qd          = 4'h0;
        if (dv.start) begin
            next_busy  = 1'h1;
            next_rem_q = 16'h0000;
            next_quo   = 16'h0000;
            next_src   = dv.dividend;
            // widen every digit first so a four-digit divisor cannot wrap mid-sum
            next_dsr   = 16'(dv.divisor[15:12]) * 16'h03E8 + 16'(dv.divisor[11:8]) * 16'h0064
                         + 16'(dv.divisor[7:4]) * 16'h000A + 16'(dv.divisor[3:0]);
            next_dig   = 3'h0;
        end else if (busy) begin
            next_rem_q = 16'(rem_q * 4'hA + src[15:12]);
            for (int i = 0; i < 9; i++) begin
                if (next_rem_q >= dsr && dsr != 16'h0000) begin
                    next_rem_q = 16'(next_rem_q - dsr);
                    qd         = 4'(qd + 4'h1);
                end
            end
            next_quo = {quo[11:0], qd};
            next_src = {src[11:0], 4'h0};
            next_dig = 3'(dig + 3'h1);
            if (dig == 3'(`BBAU_DIGITS - 1)) begin
                next_busy   = 1'h0;
                next_done_r = 1'h1;
                next_quo_o  = {quo[11:0], qd};
                next_rem_o  = {4'(next_rem_q / 10'h3E8), 4'((next_rem_q / 7'h64) % 4'hA),
                               4'((next_rem_q / 4'hA) % 4'hA), 4'(next_rem_q % 4'hA)};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            rem_q  <= `BBAU_WORD_RST;
            quo    <= `BBAU_WORD_RST;
            dsr    <= `BBAU_WORD_RST;
            src    <= `BBAU_WORD_RST;
            dig    <= 3'h0;
            busy   <= 1'h0;
            done_r <= 1'h0;
            quo_o  <= `BBAU_WORD_RST;
            rem_o  <= `BBAU_WORD_RST;
        end else begin
            rem_q  <= next_rem_q;
            quo    <= next_quo;
            dsr    <= next_dsr;
            src    <= next_src;
            dig    <= next_dig;
            busy   <= next_busy;
            done_r <= next_done_r;
            quo_o  <= next_quo_o;
            rem_o  <= next_rem_o;
        end
    end
endmodule : bbau_bcd_div
`default_nettype wire

// File: hw/bbau_consts.svh
// constants of the decimal and binary word arithmetic unit
// Behaviour
// RQ1: decimal divide raises error when dividend or divisor holds a non-decimal nibble.
// RQ2: error raised when an indirect data-memory pointer is non-decimal or out of range.
// RQ3: every executed arithmetic operation sets zero flag exactly when result is zero; divide tests only the quotient word, not the remainder.
// RQ4: binary operations treat words as plain 16-bit unsigned values.
// RQ5: binary add and subtract consume carry and also update it.
// RQ6: separate operations force carry to one and to zero.
// RQ7: binary add sums augend, addend and carry; low 16 bits to result.
// RQ8: binary add sets carry when full sum exceeds FFFF, else clears.
// RQ9: binary subtract takes subtrahend and carry from minuend into result.
// RQ10: negative difference is written as 16-bit two's complement wrap.
// RQ11: subtract carry set exactly when minuend below subtrahend plus carry.
// RQ12: binary multiply stores low product word first, high word next.
// RQ13: false execution condition changes no result word and no flag.
// RQ14: decimal divide writes quotient to first word, remainder to next.
`ifndef BBAU_CONSTS_SVH
`define BBAU_CONSTS_SVH
`define BBAU_WORD_W      16
`define BBAU_DIGITS      4
`define BBAU_DIV_STEPS   5'h10
`define BBAU_DM_LIMIT    16'h1999
`define BBAU_FLAG_RST    1'h0
`define BBAU_WORD_RST    16'h0000
`endif

// File: hw/bbau_div_if.sv
// handshake between the unit and its serial divider
`timescale 1ns/10ps
`default_nettype none
interface bbau_div_if;
    logic                 start;
    logic [15:0]          dividend;
    logic [15:0]          divisor;
    logic                 done;
    logic [15:0]          quotient;
    logic [15:0]          remainder;
    modport ctl (output start, output dividend, output divisor,
                 input done, input quotient, input remainder);
    modport div (input start, input dividend, input divisor,
                 output done, output quotient, output remainder);
endinterface : bbau_div_if
`default_nettype wire

// File: hw/bbau_pkg.sv
// types of the word arithmetic unit
package bbau_pkg;
    typedef logic [15:0] bbau_word_t;
    typedef enum logic [2:0] {
        BBAU_OP_ADD    = 3'h0,
        BBAU_OP_SUB    = 3'h1,
        BBAU_OP_MUL    = 3'h2,
        BBAU_OP_DIV    = 3'h3,
        BBAU_OP_SETC   = 3'h4,
        BBAU_OP_CLRC   = 3'h5
    } bbau_op_e;
    typedef enum logic [1:0] {
        BBAU_IDLE = 2'h0,
        BBAU_DIVL = 2'h1,
        BBAU_DONE = 2'h2
    } bbau_state_e;
endpackage : bbau_pkg

// File: hw/bbau_unit.sv
// word arithmetic unit: binary add/sub/mul, decimal divide, carry control
`timescale 1ns/10ps
`default_nettype none
`include "bbau_consts.svh"
module bbau_unit (
    // clock and reset
    input  wire logic        ref_clk,
    input  wire logic        reset,
    // instruction request
    input  wire logic        op_valid,
    input  wire logic        exec_cond,
    input  wire logic [2:0]  op_code,
    input  wire logic [15:0] operand_a,
    input  wire logic [15:0] operand_b,
    // indirect pointer status of operand fetch
    input  wire logic        ptr_used,
    input  wire logic [15:0] ptr_value,
    // answer
    output logic             op_ready,
    output logic             result_valid,
    output logic             result_wr_hi,
    output logic [15:0]      result_lo,
    output logic [15:0]      result_hi,
    // flags
    output logic             carry_flag,
    output logic             error_flag,
    output logic             zero_result_flag
);
    bbau_div_if dvi ();

    bbau_pkg::bbau_state_e state, next_state;
    logic        cy, next_cy;
    logic        er, next_er;
    logic        eq, next_eq;
    logic [15:0] r_lo, next_r_lo;
    logic [15:0] r_hi, next_r_hi;
    logic        rv, next_rv;
    logic        rwh, next_rwh;
    logic        dstart;
    logic [15:0] da, db;
    logic [16:0] sum17;
    logic [16:0] sub17;
    logic [31:0] prod;
    logic        ptr_bad;

    function automatic logic is_bcd(input logic [15:0] w);
        logic ok;
        ok = 1'h1;
        for (int i = 0; i < 4; i++) begin
            if (w[i*4 +: 4] > 4'h9) begin
                ok = 1'h0;
            end
        end
        return ok;
    endfunction : is_bcd

    bbau_bcd_div u_div (
        .ref_clk (ref_clk),
        .reset   (reset),
        .dv      (dvi.div)
    );

    assign dvi.start    = dstart;
    assign dvi.dividend = da;
    assign dvi.divisor  = db;

    // a pointer must be a decimal number inside the data-memory area
    assign ptr_bad = ptr_used && (!is_bcd(ptr_value) || ptr_value > `BBAU_DM_LIMIT); // see RQ2
    assign sum17   = {1'h0, operand_a} + {1'h0, operand_b} + {16'h0000, cy}; // see RQ4 see RQ7
    assign sub17   = {1'h0, operand_a} - {1'h0, operand_b} - {16'h0000, cy}; // see RQ9
    assign prod    = operand_a * operand_b; // see RQ12
    // divide holds off new requests until its digits are done
    assign op_ready = (state == bbau_pkg::BBAU_IDLE);

    assign carry_flag       = cy;
    assign error_flag       = er;
    assign zero_result_flag = eq;
    assign result_lo        = r_lo;
    assign result_hi        = r_hi;
    assign result_valid     = rv;
    assign result_wr_hi     = rwh;

    always_comb begin
        next_state = state;
        next_cy    = cy;
        next_er    = er;
        next_eq    = eq;
        next_r_lo  = r_lo;
        next_r_hi  = r_hi;
        next_rv    = 1'h0;
        next_rwh   = 1'h0;
        dstart     = 1'h0;
        da         = operand_a;
        db         = operand_b;
        unique case (state)
            bbau_pkg::BBAU_IDLE: begin
                // a false condition leaves words and flags alone
                if (op_valid && exec_cond) begin // see RQ13
                    unique case (bbau_pkg::bbau_op_e'(op_code))
                        bbau_pkg::BBAU_OP_ADD: begin
                            next_er   = ptr_bad;
                            next_r_lo = sum17[15:0]; // see RQ7
                            next_cy   = sum17[16]; // see RQ5 see RQ8
                            next_eq   = (sum17[15:0] == 16'h0000); // see RQ3
                            next_rv   = 1'h1;
                        end
                        bbau_pkg::BBAU_OP_SUB: begin
                            next_er   = ptr_bad;
                            next_r_lo = sub17[15:0]; // see RQ10
                            next_cy   = ({1'h0, operand_a} < {1'h0, operand_b} + {16'h0000, cy}); // see RQ5 see RQ11
                            next_eq   = (sub17[15:0] == 16'h0000); // see RQ3
                            next_rv   = 1'h1;
                        end
                        bbau_pkg::BBAU_OP_MUL: begin
                            next_er   = ptr_bad;
                            next_r_lo = prod[15:0]; // see RQ12
                            next_r_hi = prod[31:16];
                            next_eq   = (prod == 32'h00000000); // see RQ3
                            next_rv   = 1'h1;
                            next_rwh  = 1'h1;
                        end
                        bbau_pkg::BBAU_OP_DIV: begin
                            // bad digits end the divide at once, results untouched
                            if (!is_bcd(operand_a) || !is_bcd(operand_b) || ptr_bad) begin // see RQ1
                                next_er = 1'h1;
                                next_rv = 1'h1;
                            end else begin
                                next_er    = 1'h0;
                                dstart     = 1'h1;
                                next_state = bbau_pkg::BBAU_DIVL;
                            end
                        end
                        bbau_pkg::BBAU_OP_SETC: next_cy = 1'h1; // see RQ6
                        bbau_pkg::BBAU_OP_CLRC: next_cy = 1'h0; // see RQ6
                        default: next_er = er;
                    endcase
                end
            end
            bbau_pkg::BBAU_DIVL: begin
                if (dvi.done) begin
                    next_r_lo  = dvi.quotient; // see RQ14
                    next_r_hi  = dvi.remainder;
                    next_eq    = (dvi.quotient == 16'h0000); // see RQ3
                    next_rv    = 1'h1;
                    next_rwh   = 1'h1;
                    next_state = bbau_pkg::BBAU_IDLE;
                end
            end
            default: next_state = bbau_pkg::BBAU_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state <= bbau_pkg::BBAU_IDLE;
            cy    <= `BBAU_FLAG_RST;
            er    <= `BBAU_FLAG_RST;
            eq    <= `BBAU_FLAG_RST;
            r_lo  <= `BBAU_WORD_RST;
            r_hi  <= `BBAU_WORD_RST;
            rv    <= 1'h0;
            rwh   <= 1'h0;
        end else begin
            state <= next_state;
            cy    <= next_cy;
            er    <= next_er;
            eq    <= next_eq;
            r_lo  <= next_r_lo;
            r_hi  <= next_r_hi;
            rv    <= next_rv;
            rwh   <= next_rwh;
        end
    end
endmodule : bbau_unit
`default_nettype wire

// File: testbench/bbau_unit_props.sv
// port-level assertions for the word arithmetic unit
`timescale 1ns/10ps
`default_nettype none
module bbau_unit_props (
    // clock and reset
    input wire logic        ref_clk,
    input wire logic        reset,
    // request
    input wire logic        op_valid,
    input wire logic        exec_cond,
    input wire logic [2:0]  op_code,
    input wire logic [15:0] operand_a,
    input wire logic [15:0] operand_b,
    input wire logic        ptr_used,
    input wire logic [15:0] ptr_value,
    // answer and flags
    input wire logic        op_ready,
    input wire logic        result_valid,
    input wire logic        result_wr_hi,
    input wire logic [15:0] result_lo,
    input wire logic [15:0] result_hi,
    input wire logic        carry_flag,
    input wire logic        error_flag,
    input wire logic        zero_result_flag
);
    logic        take;
    logic        clean;
    logic [16:0] add_sum;
    logic [16:0] sub_need;
    logic [15:0] sub_diff;
    logic [31:0] mul_prod;
    function automatic logic not_bcd(input logic [15:0] w);
        not_bcd = (w[3:0] > 4'h9) || (w[7:4] > 4'h9) || (w[11:8] > 4'h9) || (w[15:12] > 4'h9);
    endfunction : not_bcd
    assign take = op_valid && exec_cond && op_ready;
    // pointer faults void the arithmetic checks, so those only look at direct operands
    assign clean = take && !ptr_used;
    assign add_sum = {1'h0, operand_a} + {1'h0, operand_b} + {16'h0000, carry_flag};
    assign sub_need = {1'h0, operand_b} + {16'h0000, carry_flag};
    assign sub_diff = operand_a - operand_b - {15'h0000, carry_flag};
    assign mul_prod = {16'h0000, operand_a} * {16'h0000, operand_b};
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    a_add_result: assert property (clean && op_code == 3'h0 |=> result_valid &&
        result_lo == $past(add_sum[15:0])) else $error("add result wrong");
    a_add_carry: assert property (clean && op_code == 3'h0 |=>
        carry_flag == $past(add_sum[16])) else $error("add carry wrong");
    a_sub_result: assert property (clean && op_code == 3'h1 |=>
        result_lo == $past(sub_diff)) else $error("subtract result wrong");
    a_sub_borrow: assert property (clean && op_code == 3'h1 |=>
        carry_flag == $past({1'h0, operand_a} < sub_need)) else $error("subtract carry wrong");
    a_mul_words: assert property (clean && op_code == 3'h2 |=> result_wr_hi &&
        {result_hi, result_lo} == $past(mul_prod)) else $error("product words wrong");
    a_zero_flag: assert property (result_valid && !result_wr_hi && !error_flag |->
        zero_result_flag == (result_lo == 16'h0000)) else $error("zero flag wrong");
    a_skip_hold: assert property (op_valid && !exec_cond && op_ready |=> !result_valid &&
        $stable(carry_flag) && $stable(result_lo)) else $error("skipped op changed state");
    a_carry_set: assert property (take && op_code == 3'h4 |=> carry_flag &&
        !result_valid) else $error("carry preset failed");
    a_carry_clr: assert property (take && op_code == 3'h5 |=> !carry_flag)
        else $error("carry clear failed");
    a_div_bound: assert property (take && op_code == 3'h3 |-> ##[1:20] result_valid)
        else $error("divide never finished");
    a_div_digit: assert property (take && op_code == 3'h3 && (not_bcd(operand_a) ||
        not_bcd(operand_b)) |=> result_valid && error_flag) else $error("digit error missed");
    a_ptr_fault: assert property (take && ptr_used && op_code == 3'h0 &&
        (ptr_value > 16'h1999 || not_bcd(ptr_value)) |=> error_flag) else $error("pointer error missed");
endmodule : bbau_unit_props
`default_nettype wire

// File: testbench/bbau_unit_test.sv
// self-checking testbench for the word arithmetic unit
`timescale 1ns/10ps
`default_nettype none
module bbau_unit_test;
    logic        ref_clk, reset, op_valid, exec_cond, ptr_used;
    logic [2:0]  op_code;
    logic [15:0] operand_a, operand_b, ptr_value, result_lo, result_hi;
    logic        op_ready, result_valid, result_wr_hi, carry_flag, error_flag, zero_result_flag;
    logic        seen, seen_hi, seen_busy;
    int          fail_count, n_checks, i;
    bbau_unit dut (.ref_clk(ref_clk), .reset(reset), .op_valid(op_valid),
        .exec_cond(exec_cond), .op_code(op_code), .operand_a(operand_a),
        .operand_b(operand_b), .ptr_used(ptr_used), .ptr_value(ptr_value),
        .op_ready(op_ready), .result_valid(result_valid), .result_wr_hi(result_wr_hi),
        .result_lo(result_lo), .result_hi(result_hi), .carry_flag(carry_flag),
        .error_flag(error_flag), .zero_result_flag(zero_result_flag));
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : wrap_up
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check
    // flags packed as {carry, error, zero} for one compare
    function automatic logic [15:0] flags();
        flags = {13'h0000, carry_flag, error_flag, zero_result_flag};
    endfunction : flags
    task automatic run_op(input logic [2:0] op, input logic [15:0] a, input logic [15:0] b,
                          input logic ec, input logic ptr, input logic want);
        int n;
        n = 0;
        while (op_ready !== 1'b1 && n < 30) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (op_ready !== 1'b1) begin
            fail_count++;
            $display("ERROR at %0t: unit never ready for op %h", $time, op);
            wrap_up();
        end
        @(posedge ref_clk);
        op_valid <= 1'b1;
        op_code <= op;
        operand_a <= a;
        operand_b <= b;
        exec_cond <= ec;
        ptr_used <= ptr;
        @(posedge ref_clk);
        op_valid <= 1'b0;
        ptr_used <= 1'b0;
        #1;
        seen_busy = !op_ready;
        // without an expected answer only a short quiet window is watched
        n = 0;
        while (result_valid !== 1'b1 && n < (want ? 30 : 3)) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        seen = result_valid;
        seen_hi = result_wr_hi;
        if (want && seen !== 1'b1) begin
            fail_count++;
            $display("ERROR at %0t: no result for op %h", $time, op);
            wrap_up();
        end
        check({15'h0000, seen}, {15'h0000, want}, "result strobe");
    endtask : run_op
    initial begin
        reset = 1'b1;
        op_valid = 1'b0;
        exec_cond = 1'b0;
        op_code = 3'h0;
        operand_a = 16'h0000;
        operand_b = 16'h0000;
        ptr_used = 1'b0;
        ptr_value = 16'h0000;
        fail_count = 0;
        n_checks = 0;
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        #1;
        check(flags(), 16'h0000, "reset flags");
        check(result_lo, 16'h0000, "reset low word");
        run_op(3'h4, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check(flags(), 16'h0004, "carry preset");
        run_op(3'h5, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
        check(flags(), 16'h0000, "carry clear");
        $display("test carry control done");
        run_op(3'h0, 16'hA6E2, 16'h80C5, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h27A7, "add sum");
        check(flags(), 16'h0004, "add carry out");
        check({15'h0000, seen_hi}, 16'h0000, "add writes one word");
        check({15'h0000, seen_busy}, 16'h0000, "ready after add");
        run_op(3'h0, 16'h0000, 16'hFFFF, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h0000, "add with carry in");
        check(flags(), 16'h0005, "add carry and zero");
        $display("test add done");
        run_op(3'h1, 16'h1234, 16'h0001, 1'b0, 1'b0, 1'b0);
        check(result_lo, 16'h0000, "skipped op word");
        check(flags(), 16'h0005, "skipped op flags");
        $display("test skip done");
        run_op(3'h5, 16'h0000, 16'h0000, 1'b1, 1'b0, 1'b0);
        run_op(3'h1, 16'h5A10, 16'h60E3, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'hF92D, "negative difference");
        check(flags(), 16'h0004, "borrow out");
        run_op(3'h1, 16'h0005, 16'h0004, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h0000, "difference with borrow in");
        check(flags(), 16'h0001, "no borrow zero");
        $display("test subtract done");
        run_op(3'h2, 16'hFFFF, 16'hFFFF, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h0001, "product low word");
        check(result_hi, 16'hFFFE, "product high word");
        check({15'h0000, seen_hi}, 16'h0001, "product high strobe");
        check(flags(), 16'h0000, "product flags");
        $display("test multiply done");
        run_op(3'h3, 16'h9999, 16'h1234, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h0008, "quotient by four digits");
        check(result_hi, 16'h0127, "remainder by four digits");
        run_op(3'h3, 16'h3452, 16'h0003, 1'b1, 1'b0, 1'b1);
        check(result_lo, 16'h1150, "quotient");
        check(result_hi, 16'h0002, "remainder");
        check({15'h0000, seen_busy}, 16'h0001, "busy during divide");
        check({15'h0000, seen_hi}, 16'h0001, "divide writes two words");
        run_op(3'h3, 16'h12A4, 16'h0003, 1'b1, 1'b0, 1'b1);
        check({15'h0000, error_flag}, 16'h0001, "digit error");
        check(result_lo, 16'h1150, "words kept on error");
        $display("test divide done");
        // last pointer sits exactly on the area limit and must be accepted
        for (i = 0; i < 3; i++) begin
            @(posedge ref_clk);
            ptr_value <= (i == 0) ? 16'h2000 : ((i == 1) ? 16'h00A0 : 16'h1999);
            run_op(3'h0, 16'h0001, 16'h0001, 1'b1, 1'b1, 1'b1);
            check({15'h0000, error_flag}, (i < 2) ? 16'h0001 : 16'h0000, "pointer error");
        end
        $display("test pointer done");
        wrap_up();
    end
endmodule : bbau_unit_test
bind bbau_unit bbau_unit_props u_props (.ref_clk(ref_clk), .reset(reset),
    .op_valid(op_valid), .exec_cond(exec_cond), .op_code(op_code), .operand_a(operand_a),
    .operand_b(operand_b), .ptr_used(ptr_used), .ptr_value(ptr_value), .op_ready(op_ready),
    .result_valid(result_valid), .result_wr_hi(result_wr_hi), .result_lo(result_lo),
    .result_hi(result_hi), .carry_flag(carry_flag), .error_flag(error_flag),
    .zero_result_flag(zero_result_flag));
`default_nettype wire
